// >>> src/etm_consts.vh
// Purpose: shared constants of the enhanced timer block
// Assumes: included by bare name from the channel output and timer design files
// Notes: register byte offsets, field positions, reset values, mode codes
`ifndef ETM_CONSTS_VH
`define ETM_CONSTS_VH

// register byte offsets on the apb window
`define ETM_ADDR_CTRL1      8'h00
`define ETM_ADDR_CTRL2      8'h04
`define ETM_ADDR_CMPA       8'h08
`define ETM_ADDR_CMPB       8'h0c
`define ETM_ADDR_COUNT      8'h10
`define ETM_ADDR_FLAGS      8'h14

// timer_control_one fields
`define ETM_C1_RUN          0
`define ETM_C1_CLRSEL       1
`define ETM_C1_ALIGN        2
`define ETM_C1_AMODE        4
`define ETM_C1_APF          6
`define ETM_C1_ALEVEL       8
`define ETM_C1_AINV         9
`define ETM_C1_PERIOD       10

// timer_control_two fields
`define ETM_C2_BMODE        0
`define ETM_C2_BPF          2
`define ETM_C2_BLEVEL       4
`define ETM_C2_BINV         5

// flag register bits, write one to clear
`define ETM_FLAG_A          0
`define ETM_FLAG_B          1
`define ETM_FLAG_P          2

// reset values
`define ETM_RST_CMP         10'h000
`define ETM_RST_PAIR        2'h0
`define ETM_RST_PERIOD      3'h0
`define ETM_RST_FLAGS       3'h0

// channel mode pair codes
`define ETM_MSEL_CMP        2'h0
`define ETM_MSEL_CAPT       2'h1
`define ETM_MSEL_PWM        2'h2
`define ETM_MSEL_TIMER      2'h3

// pin function pair codes in pwm and single pulse modes
`define ETM_PF_LOW          2'h0
`define ETM_PF_HIGH         2'h1
`define ETM_PF_PWM          2'h2
`define ETM_PF_ONESHOT      2'h3

// pin function pair codes in capture mode
`define ETM_EDGE_RISE       2'h0
`define ETM_EDGE_FALL       2'h1
`define ETM_EDGE_BOTH       2'h2

`define ETM_ALIGN_CENTRE    2'h3
`define ETM_PERIOD_LOWBITS  7'h7f
`define ETM_PERIOD_ZERO     7'h00
`define ETM_COUNT_MAX       10'h3ff

`endif

// >>> src/etm_pin_sync.v
// Purpose: bring an outside pin into the clk domain and find its edges
// Assumes: pin is asynchronous to clk
// Notes: edges appear two edges after the pin moves
`timescale 1ns/1ps
module etm_pin_sync (
	input  wire clk,
	input  wire rst_b,
	input  wire pinIn,
	output wire rise,
	output wire fall
);

	reg meta;
	reg stable;
	reg last;

	// meta is read by stable alone, so no logic sees a metastable level
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
		end else begin
			meta   <= pinIn;
			stable <= meta;
			last   <= stable;
		end
	end

	assign rise = stable & ~last;
	assign fall = ~stable & last;

endmodule

// >>> src/etm_chan_out.v
// Purpose: one channel output stage: compare action, pwm shaping, polarity
// Assumes: all inputs come from logic on clk
// Notes: pin and enable are registered; enable is low while driving
`timescale 1ns/1ps
`include "etm_consts.vh"
module etm_chan_out (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       cmpDrive,
	input  wire       waveDrive,
	input  wire       waveActive,
	input  wire       matchEvt,
	input  wire       runRise,
	input  wire       outputLevel,
	input  wire       invert,
	input  wire [1:0] pinFunction,
	output reg        pinOut,
	output reg        pinOe_b
);

	reg  cmpState;
	reg  waveVal;
	reg  next_pinOut;

	always @* begin
		case (pinFunction)
			`ETM_PF_LOW:  waveVal = 1'b0;
			`ETM_PF_HIGH: waveVal = 1'b1;
			default:      waveVal = waveActive ? outputLevel : ~outputLevel;
		endcase
		if (cmpDrive)
			next_pinOut = cmpState ^ invert;
		else if (waveDrive)
			next_pinOut = waveVal ^ invert;
		else
			next_pinOut = 1'b0;
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmpState <= 1'b0;
			pinOut   <= 1'b0;
			pinOe_b  <= 1'b1;
		end else begin
			if (runRise)
				cmpState <= outputLevel;
			else if (matchEvt) begin
				case (pinFunction)
					2'h1:    cmpState <= 1'b0;
					2'h2:    cmpState <= 1'b1;
					2'h3:    cmpState <= ~cmpState;
					default: cmpState <= cmpState;
				endcase
			end
			pinOut  <= next_pinOut;
			pinOe_b <= ~(cmpDrive | waveDrive);
		end
	end

endmodule

// >>> src/etm_timer.v
// Purpose: enhanced timer: compare, timer, pwm, single pulse and capture modes
// Assumes: apb slave on clk, zero wait states; counter ticks on every clk
// Notes: pins are split into in, out and active-low enable
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "etm_consts.vh"
module etm_timer (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        chanAPinIn,
	output wire        chanAPinOut,
	output wire        chanAPinOe_b,
	input  wire        chanBPinIn,
	output wire        chanBPinOut,
	output wire        chanBPinOe_b,
	input  wire        externalTickPin
);

	localparam MODE_CMP    = 3'h0;
	localparam MODE_TIMER  = 3'h1;
	localparam MODE_PWM    = 3'h2;
	localparam MODE_SINGLE = 3'h3;
	localparam MODE_CAPT   = 3'h4;

	// edge selection shared by both capture channels
	function edgeHit;
		input [1:0] sel;
		input       rise;
		input       fall;
		begin
			case (sel)
				`ETM_EDGE_RISE: edgeHit = rise;
				`ETM_EDGE_FALL: edgeHit = fall;
				`ETM_EDGE_BOTH: edgeHit = rise | fall;
				default:        edgeHit = 1'b0;
			endcase
		end
	endfunction

	reg        counterRun;
	reg        clearSelect;
	reg  [1:0] alignSelect;
	reg  [2:0] periodField;
	reg  [1:0] chanAModeSel;
	reg  [1:0] chanBModeSel;
	reg  [1:0] chanAPinFunction;
	reg  [1:0] chanBPinFunction;
	reg        chanAOutputLevel;
	reg        chanBOutputLevel;
	reg        chanAInvert;
	reg        chanBInvert;
	reg  [9:0] compareAValue;
	reg  [9:0] compareBValue;
	reg  [9:0] count;
	reg        countDown;
	reg        runLast;
	reg        pulseB;
	reg  [2:0] flags;
	reg  [2:0] mode;
	reg  [9:0] termVal;
	reg  [9:0] centreTop;
	reg  [2:0] flagEvt;
	reg  [1:0] waveActive;
	reg  [1:0] waveDrive;
	reg  [31:0] next_prdata;
	reg        addrHit;

	wire       runRise;
	wire       centre;
	wire       atTerm;
	wire       matchA;
	wire       matchB;
	wire       capA;
	wire       capB;
	wire       riseA;
	wire       fallA;
	wire       riseB;
	wire       fallB;
	wire       tickRise;
	wire       wrEn;
	wire       setupRd;
	wire [9:0] edgeTerm;
	wire [1:0] cmpDrive;
	wire [1:0] pinOut;
	wire [1:0] pinOe_b;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	etm_pin_sync syncA (
		.clk   (clk),
		.rst_b (rst_b),
		.pinIn (chanAPinIn),
		.rise  (riseA),
		.fall  (fallA)
	);

	etm_pin_sync syncB (
		.clk   (clk),
		.rst_b (rst_b),
		.pinIn (chanBPinIn),
		.rise  (riseB),
		.fall  (fallB)
	);

	etm_pin_sync syncTick (
		.clk   (clk),
		.rst_b (rst_b),
		.pinIn (externalTickPin),
		.rise  (tickRise),
		.fall  ()
	);

	////////////////////////////////////////////////////////////////////////
	// mode decode

	always @* begin
		if (chanAModeSel == `ETM_MSEL_TIMER && chanBModeSel == `ETM_MSEL_TIMER)
			mode = MODE_TIMER;
		else if (chanAModeSel == `ETM_MSEL_CAPT && chanBModeSel == `ETM_MSEL_CAPT)
			mode = MODE_CAPT;
		else if (chanAModeSel == `ETM_MSEL_PWM && chanBModeSel == `ETM_MSEL_PWM) begin
			if (chanAPinFunction == `ETM_PF_ONESHOT && chanBPinFunction == `ETM_PF_ONESHOT)
				mode = MODE_SINGLE;
			else
				mode = MODE_PWM;
		end else
			mode = MODE_CMP;
	end

	assign centre   = (mode == MODE_PWM) && (alignSelect == `ETM_ALIGN_CENTRE);
	assign runRise  = counterRun & ~runLast;

	// code n gives n*128 steps; code 0 wraps the subtraction to 1023
	assign edgeTerm = {periodField - 3'h1, `ETM_PERIOD_LOWBITS};

	always @* begin
		case (mode)
			MODE_PWM:
				termVal = clearSelect ? compareAValue - 10'h001 : edgeTerm;
			MODE_CAPT:
				termVal = edgeTerm;
			default:
				termVal = clearSelect ? compareAValue : edgeTerm;
		endcase
		if (clearSelect)
			centreTop = compareAValue;
		else if (periodField == 3'h0)
			centreTop = `ETM_COUNT_MAX;
		else
			centreTop = {periodField, `ETM_PERIOD_ZERO};
	end

	assign atTerm = (count == termVal);
	assign matchA = counterRun & (count == compareAValue);
	assign matchB = counterRun & (count == compareBValue);
	assign capA   = (mode == MODE_CAPT) & edgeHit(chanAPinFunction, riseA, fallA);
	assign capB   = (mode == MODE_CAPT) & edgeHit(chanBPinFunction, riseB, fallB);

	////////////////////////////////////////////////////////////////////////
	// counter

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count     <= 10'h000;
			countDown <= 1'b0;
			runLast   <= 1'b0;
		end else begin
			runLast <= counterRun;
			if (mode == MODE_SINGLE) begin
				if (runRise)
					count <= 10'h000;
				else if (counterRun)
					count <= count + 10'h001;
			end else if (centre) begin
				if (counterRun) begin
					// up to the top, back down to zero
					if (!countDown && count >= centreTop) begin
						countDown <= 1'b1;
						count     <= count - 10'h001;
					end else if (countDown && count == 10'h000) begin
						countDown <= 1'b0;
						count     <= 10'h001;
					end else if (countDown)
						count <= count - 10'h001;
					else
						count <= count + 10'h001;
				end
			end else if (counterRun) begin
				countDown <= 1'b0;
				count     <= atTerm ? 10'h000 : count + 10'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag events and waveforms

	always @* begin
		flagEvt    = 3'h0;
		waveActive = 2'h0;
		waveDrive  = 2'h0;
		case (mode)
			MODE_CAPT: begin
				flagEvt[`ETM_FLAG_A] = capA;
				flagEvt[`ETM_FLAG_B] = capB;
				flagEvt[`ETM_FLAG_P] = counterRun & atTerm;
			end
			MODE_SINGLE: begin
				flagEvt[`ETM_FLAG_A] = matchA;
				flagEvt[`ETM_FLAG_B] = matchB;
				waveActive = {pulseB, counterRun};
				waveDrive  = 2'h3;
			end
			MODE_PWM: begin
				if (clearSelect && !centre)
					flagEvt[`ETM_FLAG_A] = counterRun & atTerm;
				else
					flagEvt[`ETM_FLAG_A] = matchA;
				flagEvt[`ETM_FLAG_B] = matchB;
				if (centre)
					flagEvt[`ETM_FLAG_P] = counterRun & ~clearSelect & countDown &
						(count == 10'h001);
				else
					flagEvt[`ETM_FLAG_P] = counterRun & ~clearSelect & atTerm;
				waveActive[0] = (count < compareAValue);
				waveActive[1] = (count < compareBValue);
				waveDrive     = {1'b1, ~clearSelect};
			end
			default: begin
				flagEvt[`ETM_FLAG_A] = matchA;
				flagEvt[`ETM_FLAG_B] = matchB;
				flagEvt[`ETM_FLAG_P] = counterRun & ~clearSelect & atTerm;
			end
		endcase
	end

	// pulse B starts on the B match and falls with run
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			pulseB <= 1'b0;
		else if (mode != MODE_SINGLE || !counterRun || matchA)
			pulseB <= 1'b0;
		else if (matchB)
			pulseB <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// channel output stages

	assign cmpDrive = {2{mode == MODE_CMP}};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chanGen
			etm_chan_out outStage (
				.clk         (clk),
				.rst_b       (rst_b),
				.cmpDrive    (cmpDrive[ch]),
				.waveDrive   (waveDrive[ch]),
				.waveActive  (waveActive[ch]),
				.matchEvt    (ch == 0 ? matchA : matchB),
				.runRise     (runRise),
				.outputLevel (ch == 0 ? chanAOutputLevel : chanBOutputLevel),
				.invert      (ch == 0 ? chanAInvert : chanBInvert),
				.pinFunction (ch == 0 ? chanAPinFunction : chanBPinFunction),
				.pinOut      (pinOut[ch]),
				.pinOe_b     (pinOe_b[ch])
			);
		end
	endgenerate

	assign chanAPinOut  = pinOut[0];
	assign chanBPinOut  = pinOut[1];
	assign chanAPinOe_b = pinOe_b[0];
	assign chanBPinOe_b = pinOe_b[1];

	////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states

	assign pready  = 1'b1;
	assign wrEn    = psel & penable & pwrite & addrHit;
	assign setupRd = psel & ~penable & ~pwrite;
	assign pslverr = psel & penable & ~addrHit;

	always @* begin
		addrHit     = 1'b1;
		next_prdata = 32'h0000_0000;
		case (paddr)
			`ETM_ADDR_CTRL1: begin
				next_prdata[`ETM_C1_RUN]           = counterRun;
				next_prdata[`ETM_C1_CLRSEL]        = clearSelect;
				next_prdata[`ETM_C1_ALIGN+:2]      = alignSelect;
				next_prdata[`ETM_C1_AMODE+:2]      = chanAModeSel;
				next_prdata[`ETM_C1_APF+:2]        = chanAPinFunction;
				next_prdata[`ETM_C1_ALEVEL]        = chanAOutputLevel;
				next_prdata[`ETM_C1_AINV]          = chanAInvert;
				next_prdata[`ETM_C1_PERIOD+:3]     = periodField;
			end
			`ETM_ADDR_CTRL2: begin
				next_prdata[`ETM_C2_BMODE+:2]      = chanBModeSel;
				next_prdata[`ETM_C2_BPF+:2]        = chanBPinFunction;
				next_prdata[`ETM_C2_BLEVEL]        = chanBOutputLevel;
				next_prdata[`ETM_C2_BINV]          = chanBInvert;
			end
			`ETM_ADDR_CMPA:  next_prdata[9:0] = compareAValue;
			`ETM_ADDR_CMPB:  next_prdata[9:0] = compareBValue;
			`ETM_ADDR_COUNT: next_prdata[9:0] = count;
			`ETM_ADDR_FLAGS: next_prdata[2:0] = flags;
			default:         addrHit = 1'b0;
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			prdata <= 32'h0000_0000;
		else if (setupRd)
			prdata <= next_prdata;
	end

	// control registers; hardware run changes win over a same-cycle write
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			counterRun       <= 1'b0;
			clearSelect      <= 1'b0;
			alignSelect      <= `ETM_RST_PAIR;
			periodField      <= `ETM_RST_PERIOD;
			chanAModeSel     <= `ETM_RST_PAIR;
			chanBModeSel     <= `ETM_RST_PAIR;
			chanAPinFunction <= `ETM_RST_PAIR;
			chanBPinFunction <= `ETM_RST_PAIR;
			chanAOutputLevel <= 1'b0;
			chanBOutputLevel <= 1'b0;
			chanAInvert      <= 1'b0;
			chanBInvert      <= 1'b0;
		end else begin
			if (wrEn && paddr == `ETM_ADDR_CTRL1) begin
				counterRun       <= pwdata[`ETM_C1_RUN];
				clearSelect      <= pwdata[`ETM_C1_CLRSEL];
				alignSelect      <= pwdata[`ETM_C1_ALIGN+:2];
				chanAModeSel     <= pwdata[`ETM_C1_AMODE+:2];
				chanAPinFunction <= pwdata[`ETM_C1_APF+:2];
				chanAOutputLevel <= pwdata[`ETM_C1_ALEVEL];
				chanAInvert      <= pwdata[`ETM_C1_AINV];
				periodField      <= pwdata[`ETM_C1_PERIOD+:3];
			end
			if (wrEn && paddr == `ETM_ADDR_CTRL2) begin
				chanBModeSel     <= pwdata[`ETM_C2_BMODE+:2];
				chanBPinFunction <= pwdata[`ETM_C2_BPF+:2];
				chanBOutputLevel <= pwdata[`ETM_C2_BLEVEL];
				chanBInvert      <= pwdata[`ETM_C2_BINV];
			end
			if (mode == MODE_SINGLE && counterRun && matchA)
				counterRun <= 1'b0;
			else if (mode == MODE_SINGLE && tickRise)
				counterRun <= 1'b1;
		end
	end

	// capture overrides a same-cycle software write to the compare value
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			compareAValue <= `ETM_RST_CMP;
			compareBValue <= `ETM_RST_CMP;
			flags         <= `ETM_RST_FLAGS;
		end else begin
			if (capA)
				compareAValue <= count;
			else if (wrEn && paddr == `ETM_ADDR_CMPA)
				compareAValue <= pwdata[9:0];
			if (capB)
				compareBValue <= count;
			else if (wrEn && paddr == `ETM_ADDR_CMPB)
				compareBValue <= pwdata[9:0];
			// set wins over a write-one clear in the same cycle
			if (wrEn && paddr == `ETM_ADDR_FLAGS)
				flags <= (flags & ~pwdata[2:0]) | flagEvt;
			else
				flags <= flags | flagEvt;
		end
	end

endmodule

// >>> bench/etm_pin_load.sv
// Purpose: far side of one channel pin: a pulse source that the pin reads while released
// Assumes: the timer's drive wins over the source while its enable is low
// Notes: a released pin follows the source level, so it reads low while the source is idle
`timescale 1ns/1ps
module etm_pin_load (
	input  wire logic pinOut,
	input  wire logic pinOe_b,
	input  wire logic srcLevel,
	output wire logic pinLevel
);
	assign pinLevel = !pinOe_b ? pinOut : srcLevel;
endmodule

// >>> bench/etm_timer_assertions.sv
// Purpose: port-level checks of the enhanced timer
// Assumes: control fields are tracked from apb writes
// Notes: a run bit cleared by hardware is not seen here; pin checks other than the one-shot start wait three cycles
`timescale 1ns/1ps
module etm_timer_assertions (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        chanAPinOut,
	input wire logic        chanAPinOe_b,
	input wire logic        chanBPinOut,
	input wire logic        chanBPinOe_b
);
	logic [12:0] ctl1;
	logic [5:0]  ctl2;
	logic [1:0]  quiet;
	wire         wrC1 = psel && penable && pwrite && pready && paddr == 8'h00;
	wire         wrC2 = psel && penable && pwrite && pready && paddr == 8'h04;
	wire         both2 = ctl1[5:4] == 2'h2 && ctl2[1:0] == 2'h2;
	wire         pwm = both2 && !(ctl1[7:6] == 2'h3 && ctl2[3:2] == 2'h3);
	wire         tmr = ctl1[5:4] == 2'h3 && ctl2[1:0] == 2'h3;
	wire         capt = ctl1[5:4] == 2'h1 && ctl2[1:0] == 2'h1;
	wire         settled = quiet == 2'h3;
	// pins lag the control write by their flops, so modes are judged only once settled, except at the one-shot start
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl1 <= 13'h0000;
			ctl2 <= 6'h00;
			quiet <= 2'h0;
		end else begin
			if (wrC1)
				ctl1 <= pwdata[12:0];
			if (wrC2)
				ctl2 <= pwdata[5:0];
			if (wrC1 || wrC2)
				quiet <= 2'h0;
			else if (quiet != 2'h3)
				quiet <= quiet + 2'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_run_rise;
		wrC1 && pwdata[0] && !ctl1[0] && pwdata[7:4] == 4'he && ctl2[3:0] == 4'he;
	endsequence
	sequence s_pin_a_moves;
		##[1:4] $changed(chanAPinOut);
	endsequence
	a_timer_pins_off: assert property (tmr && settled |-> chanAPinOe_b && chanBPinOe_b)
		else $error("timer mode drives a pin");
	a_pwm_drives_pins: assert property (pwm && !ctl1[1] && ctl1[7:6] == 2'h2
		&& ctl2[3:2] == 2'h2 && settled |-> !chanAPinOe_b && !chanBPinOe_b)
		else $error("pwm pins not driven");
	a_clr_hi_a_still: assert property (pwm && ctl1[1] && settled |=> $stable(chanAPinOut))
		else $error("pin A moves with clear-select high");
	a_force_a_level: assert property (pwm && !ctl1[1] && !ctl1[7] && settled
		|-> !chanAPinOe_b && chanAPinOut == (ctl1[6] ^ ctl1[9]))
		else $error("pin A forced level wrong");
	a_force_b_level: assert property (pwm && !ctl2[3] && settled
		|-> !chanBPinOe_b && chanBPinOut == (ctl2[2] ^ ctl2[5]))
		else $error("pin B forced level wrong");
	a_capt_pins_in: assert property (capt && settled |-> chanAPinOe_b && chanBPinOe_b)
		else $error("capture mode drives a pin");
	a_ten_bit_regs: assert property (psel && penable && !pwrite
		&& (paddr == 8'h08 || paddr == 8'h0c || paddr == 8'h10) |-> prdata[31:10] == 22'h0)
		else $error("wide compare or count value");
	a_one_shot_go: assert property (s_run_rise |-> s_pin_a_moves)
		else $error("run rise gives no pulse A");
endmodule

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the enhanced timer
// Assumes: zero-wait apb slave; pins served by two load models
// Notes: pwm polarity is judged by relations, so either active level passes
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [7:0]  a;
		logic        w;
		logic [31:0] d;
		logic [31:0] e;
		logic        err;
	} etm_row_t;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        srcA = 1'b0;
	logic        srcB = 1'b0;
	logic        tick = 1'b0;
	wire  [31:0] prdata;
	wire         pready, pslverr, aIn, aOut, aOe_b, bIn, bOut, bOe_b;
	logic [31:0] rdv, cnt;
	logic        err;
	int          nMismatch = 0;
	int          checked = 0;
	int          per, hi, hi2, wa, wb, wa2;
	etm_row_t    rows [13] = '{
		'{8'h00, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'h0, 1'b0},
		'{8'h08, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h0c, 1'b0, 32'h0, 32'h0, 1'b0},
		'{8'h08, 1'b1, 32'hffffffff, 32'h3ff, 1'b0},
		'{8'h0c, 1'b1, 32'h00000abc, 32'h2bc, 1'b0},
		'{8'h10, 1'b1, 32'h000003ff, 32'h0, 1'b0},
		'{8'h14, 1'b1, 32'h00000007, 32'h0, 1'b0},
		'{8'h18, 1'b1, 32'hffffffff, 32'h0, 1'b1},
		'{8'h00, 1'b1, 32'hfffffffe, 32'h1ffe, 1'b0},
		'{8'h04, 1'b1, 32'hffffffff, 32'h3f, 1'b0},
		'{8'h00, 1'b1, 32'h0, 32'h0, 1'b0}, '{8'h04, 1'b1, 32'h0, 32'h0, 1'b0}};
	always #25 clk = ~clk;
	etm_timer etm_timer_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chanAPinIn(aIn), .chanAPinOut(aOut), .chanAPinOe_b(aOe_b),
		.chanBPinIn(bIn), .chanBPinOut(bOut), .chanBPinOe_b(bOe_b), .externalTickPin(tick));
	etm_pin_load loadA (.pinOut(aOut), .pinOe_b(aOe_b), .srcLevel(srcA), .pinLevel(aIn));
	etm_pin_load loadB (.pinOut(bOut), .pinOe_b(bOe_b), .srcLevel(srcB), .pinLevel(bIn));
	////////////////////////////////////////////////////////////////////////////////
	task automatic miss(input string m);
		nMismatch++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, nMismatch);
		if (nMismatch == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic timeout;
		miss("wait bound used up");
		stop_test();
	endtask
	task automatic chkV(input logic [31:0] g, input logic [31:0] x, input string m);
		checked++;
		if (g !== x)
			miss($sformatf("%s got %h want %h", m, g, x));
	endtask
	task automatic chkI(input int g, input int x);
		checked++;
		if (g != x)
			miss($sformatf("count got %0d want %0d", g, x));
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20)
			timeout();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic e;
		apb(a, 1'b0, 32'h0, rdv, e);
		chkV(rdv, x, "read");
	endtask
	// skips the first rise, which may come from the mode change itself
	task automatic meas(input logic b, output int p, output int h);
		int n;
		int k;
		logic q;
		logic o;
		n = 0;
		p = 0;
		h = 0;
		o = 1'b1;
		for (k = 0; k < 4000 && n < 3; k++) begin
			@(posedge clk);
			q = b ? bOut : aOut;
			if (q === 1'b1 && o === 1'b0)
				n++;
			if (n == 2) begin
				p++;
				h += int'(q === 1'b1);
			end
			o = q;
		end
		if (n < 3)
			timeout();
	endtask
	task automatic width(input int c, output int x, output int y);
		logic sa;
		logic sb;
		sa = aOut;
		sb = bOut;
		x = 0;
		y = 0;
		repeat (c) begin
			@(posedge clk);
			x += int'(aOut !== sa);
			y += int'(bOut !== sb);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			apb(rows[i].a, 1'b0, 32'h0, rdv, err);
			chkV(rdv, rows[i].e, "register");
			chkV({31'h0, err}, {31'h0, rows[i].err}, "slave error");
		end
		wr(8'h08, 32'd10);
		wr(8'h0c, 32'd20);
		wr(8'h04, 32'h0a);
		wr(8'h00, 32'h4a1);
		meas(1'b0, per, hi);
		chkI(per, 128);
		meas(1'b1, per, hi2);
		chkI(per, 128);
		chkI(int'((hi == 10 && hi2 == 20) || (hi == 118 && hi2 == 108)), 1);
		rd(8'h14, 32'h7);
		wr(8'h00, 32'h6a1);
		meas(1'b0, per, hi2);
		chkI(hi + hi2, 128);
		wr(8'h00, 32'h421);
		wr(8'h04, 32'h06);
		wr(8'h14, 32'h7);
		repeat (300) @(posedge clk);
		rd(8'h14, 32'h7);
		wr(8'h04, 32'h0a);
		wr(8'h00, 32'h0a1);
		meas(1'b0, per, hi);
		chkI(per, 1024);
		wr(8'h08, 32'd300);
		wr(8'h00, 32'h0a3);
		meas(1'b1, per, hi);
		chkI(per, 300);
		wr(8'h08, 32'd50);
		wr(8'h0c, 32'd10);
		wr(8'h00, 32'h0af);
		wr(8'h14, 32'h7);
		meas(1'b1, per, hi);
		chkI(per, 100);
		chkI(int'(hi == 19 || hi == 81), 1);
		rd(8'h14, 32'h3);
		wr(8'h00, 32'h4ad);
		wr(8'h14, 32'h7);
		meas(1'b0, per, hi);
		chkI(per, 256);
		rd(8'h14, 32'h7);
		wr(8'h00, 32'h0e0);
		wr(8'h04, 32'h0e);
		wr(8'h08, 32'd40);
		wr(8'h0c, 32'd15);
		fork
			wr(8'h00, 32'h0e1);
			width(80, wa, wb);
		join
		// run stands from its write edge through the A match edge; the pin lags it by one
		chkI(wa, 40 + 2);
		chkI(wb, 40 - 15);
		rd(8'h00, 32'h0e0);
		fork
			begin
				tick <= 1'b1;
				repeat (4) @(posedge clk);
				tick <= 1'b0;
			end
			width(80, wa2, wb);
		join
		chkI(wa2, wa);
		wr(8'h0c, 32'h155);
		wr(8'h04, 32'h0d);
		wr(8'h00, 32'h411);
		repeat (200) @(posedge clk);
		wr(8'h00, 32'h410);
		apb(8'h10, 1'b0, 32'h0, cnt, err);
		chkI(int'(cnt < 32'd128 && cnt > 32'd0), 1);
		for (int c = 0; c < 3; c++) begin
			wr(8'h00, 32'h410 | 32'(c << 6));
			wr(8'h08, 32'h3ff);
			wr(8'h14, 32'h7);
			srcA <= 1'b1;
			srcB <= 1'b1;
			repeat (4) @(posedge clk);
			srcA <= 1'b0;
			srcB <= 1'b0;
			repeat (6) @(posedge clk);
			rd(8'h08, cnt);
			rd(8'h0c, 32'h155);
			rd(8'h14, 32'h1);
		end
		rd(8'h10, cnt);
		wr(8'h0c, 32'd20);
		wr(8'h08, 32'd40);
		wr(8'h04, 32'h03);
		wr(8'h00, 32'h033);
		wr(8'h14, 32'h7);
		// the counter first runs up through overflow from where capture left it
		repeat (1100) @(posedge clk);
		rd(8'h14, 32'h3);
		apb(8'h10, 1'b0, 32'h0, cnt, err);
		chkI(int'(cnt <= 32'd40), 1);
		// mid-run reset: pins released, registers and counter back to zero
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		chkV({28'h0, aOut, aOe_b, bOut, bOe_b}, 32'h5, "pins in reset");
		rst_b <= 1'b1;
		@(posedge clk);
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0);
		stop_test();
	end
endmodule
bind etm_timer etm_timer_assertions etm_timer_assertions_i (.clk(clk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .chanAPinOut(chanAPinOut), .chanAPinOe_b(chanAPinOe_b),
	.chanBPinOut(chanBPinOut), .chanBPinOe_b(chanBPinOe_b));
